// ### logic/sa_top.sv
// Purpose: Serial and parallel control of a 5-bit step attenuator behind a Wishbone slave.
// Assumes: clk_sys at 20 MHz oversamples the serial clock; pins pass two flip-flops first.
// Notes: Reset stands in for power-up; the preset is taken once the pin samples settle.
// Overview of operation
// - Shift register clocks regardless of latch enable.
// - Latch enable high makes latch transparent.
// - Latch enable low holds attenuation fixed; a re-arm write to the control register still reloads the power-up value.
// - Word is MSB first, start bit leads.
// - Serial data sampled on serial clock rise.
// - Serial power-up takes the parallel inputs.
// - Parallel power-up, enable low: preset pin picks.
// - Parallel power-up, enable high: inputs, preset ignored.
// - Power-up value holds until first word.
// - Interface select low parallel, high serial.
// - Direct mode follows parallel inputs immediately.
// - Bits binary weighted, 0.5 to 8 dB.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module sa_top
    import sa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input sa_pkg::sa_pins_type pins,
    input sa_pkg::sa_wb_req_type wb_req,
    output logic [sa_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    output sa_pkg::sa_atten_type atten
);
    import sa_pkg::*;

    function automatic sa_atten_type word_of_pins(input sa_pins_type p);
        return p.atten_ctrl;
    endfunction : word_of_pins

    sa_pins_type pins_s;
    sa_state_type state_reg, state_next;
    logic [1:0] settle_reg, settle_next;
    logic [SHIFT_W-1:0] shift_reg, shift_next;
    sa_atten_type atten_reg, atten_next;
    logic live_reg, live_next;
    logic sclk_prev_reg, sclk_prev_next;
    logic le_prev_reg, le_prev_next;
    logic start_err_reg, start_err_next;
    logic word_seen_reg, word_seen_next;
    logic ack_reg, ack_next;
    logic [WB_DW-1:0] dat_reg, dat_next;
    logic rearm_reg, rearm_next;
    logic sclk_rise;
    logic le_rise;
    logic serial_mode;
    logic wr_fire;
    logic [1:0] flag_clr;

    sa_sync #(.W(PINS_W)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(pins),
        .q(pins_s)
    );

    assign sclk_rise = pins_s.serial_clock & ~sclk_prev_reg;
    assign le_rise = pins_s.latch_load_enable & ~le_prev_reg;
    assign serial_mode = pins_s.interface_select;

    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        shift_next = shift_reg;
        atten_next = atten_reg;
        live_next = live_reg;
        start_err_next = start_err_reg & ~flag_clr[FLAG_START_ERR_BIT];
        word_seen_next = word_seen_reg & ~flag_clr[FLAG_WORD_BIT];
        sclk_prev_next = pins_s.serial_clock;
        le_prev_next = pins_s.latch_load_enable;
        case (state_reg)
            ST_SETTLE: begin
                if (settle_reg == SETTLE_CYCLES - 2'h1) begin
                    state_next = ST_PRESET;
                end else begin
                    settle_next = settle_reg + 2'h1;
                end
            end
            ST_PRESET: begin
                state_next = ST_RUN;
                if (serial_mode) begin
                    atten_next = word_of_pins(pins_s);
                    live_next = 1'b0;
                end else if (pins_s.latch_load_enable) begin
                    atten_next = word_of_pins(pins_s);
                    live_next = 1'b1;
                end else begin
                    atten_next = pins_s.powerup_preset_select ? ATTEN_8DB : ATTEN_REF;
                    live_next = 1'b0;
                end
            end
            ST_RUN: begin
                if (sclk_rise) begin
                    shift_next = {shift_reg[SHIFT_W-2:0], pins_s.serial_data};
                end
                if (le_rise) begin
                    live_next = 1'b1;
                    word_seen_next = 1'b1;
                    if (serial_mode && shift_reg[SHIFT_W-1]) begin
                        start_err_next = 1'b1;
                    end
                end
                // The preset stays until the first enable pulse arrives.
                if ((live_reg || le_rise) && pins_s.latch_load_enable) begin
                    if (serial_mode) begin
                        atten_next = sa_atten_type'(shift_reg[ATTEN_W-1:0]);
                    end else begin
                        atten_next = word_of_pins(pins_s);
                    end
                end
                if (rearm_reg) begin
                    state_next = ST_PRESET;
                end
            end
            default: begin
                state_next = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_SETTLE;
            settle_reg <= 2'h0;
            shift_reg <= SHIFT_RESET;
            atten_reg <= ATTEN_REF;
            live_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            le_prev_reg <= 1'b0;
            start_err_reg <= 1'b0;
            word_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            shift_reg <= shift_next;
            atten_reg <= atten_next;
            live_reg <= live_next;
            sclk_prev_reg <= sclk_prev_next;
            le_prev_reg <= le_prev_next;
            start_err_reg <= start_err_next;
            word_seen_reg <= word_seen_next;
        end
    end

    // Writes land on the edge where the master sees ack, never earlier.
    assign wr_fire = wb_req.cyc & wb_req.stb & wb_req.we & ack_reg & wb_req.sel[0];
    assign flag_clr = (wr_fire && wb_req.adr == ADDR_FLAGS) ? wb_req.dat[1:0] : 2'b00;

    always_comb begin
        ack_next = wb_req.cyc & wb_req.stb & ~ack_reg;
        dat_next = WB_ZERO;
        rearm_next = 1'b0;
        if (wr_fire && wb_req.adr == ADDR_CTRL) begin
            rearm_next = wb_req.dat[CTRL_REARM_BIT];
        end
        if (ack_next && !wb_req.we) begin
            if (wb_req.adr == ADDR_STATUS) begin
                dat_next[STAT_ATTEN_LSB +: ATTEN_W] = atten_reg;
                dat_next[STAT_SHIFT_LSB +: SHIFT_W] = shift_reg;
                dat_next[STAT_LIVE_BIT] = live_reg;
                dat_next[STAT_MODE_BIT] = serial_mode;
                dat_next[STAT_LE_BIT] = pins_s.latch_load_enable;
            end else if (wb_req.adr == ADDR_FLAGS) begin
                dat_next[FLAG_START_ERR_BIT] = start_err_reg;
                dat_next[FLAG_WORD_BIT] = word_seen_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= WB_ZERO;
            rearm_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            rearm_reg <= rearm_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign atten = atten_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_SHIFT_IN: assert property (
        (state_reg == ST_RUN && sclk_rise)
            |=> shift_reg == {$past(shift_reg[SHIFT_W-2:0]), $past(pins_s.serial_data)})
        else $error("Serial bit not shifted in on clock rise.");

    AST_SHIFT_IDLE: assert property (
        (state_reg == ST_RUN && !sclk_rise) |=> $stable(shift_reg))
        else $error("Shift register moved without a clock rise.");

    AST_TRANSPARENT: assert property (
        (state_reg == ST_RUN && live_reg && serial_mode && pins_s.latch_load_enable)
            |=> atten == $past(shift_reg[ATTEN_W-1:0]))
        else $error("Open latch does not follow the shift register.");

    AST_HOLD_LOW: assert property (
        (state_reg == ST_RUN && !pins_s.latch_load_enable) |=> $stable(atten))
        else $error("Attenuation changed while latch enable low.");

    AST_DIRECT: assert property (
        (state_reg == ST_RUN && live_reg && !serial_mode && pins_s.latch_load_enable)
            |=> atten == $past(pins_s.atten_ctrl))
        else $error("Direct mode does not follow the parallel inputs.");

    AST_PRESET_PAR: assert property (
        (state_reg == ST_PRESET && !serial_mode && !pins_s.latch_load_enable)
            |=> atten == ($past(pins_s.powerup_preset_select) ? ATTEN_8DB : ATTEN_REF)
                && state_reg == ST_RUN)
        else $error("Parallel preset value wrong.");

    AST_PRESET_PINS: assert property (
        (state_reg == ST_PRESET && (serial_mode || pins_s.latch_load_enable))
            |=> atten == $past(pins_s.atten_ctrl))
        else $error("Power-up did not take the parallel inputs.");

    AST_PRESET_KEPT: assert property (
        (state_reg == ST_RUN && !live_reg && !le_rise) |=> $stable(atten))
        else $error("Preset left before the first word.");

    AST_START_BIT: assert property (
        (state_reg == ST_RUN && le_rise && serial_mode && shift_reg[SHIFT_W-1])
            |=> start_err_reg [*2])
        else $error("Start bit error not flagged.");

    AST_BUS_ACK: assert property (
        (wb_req.cyc && wb_req.stb && !ack_reg) |=> ack_reg ##1 !ack_reg)
        else $error("Bus answer not a single cycle after the request.");
endmodule : sa_top

// ### logic/sa_pkg.sv
// Purpose: Shared constants and types of the step attenuator control block.
// Assumes: Bus word of 32 bits, byte addresses, registers one aligned word each.
// Notes: Attenuation word order is 8, 4, 2, 1 and 0.5 dB from high bit to low bit.
package sa_pkg;
    localparam int SHIFT_W = 6;
    localparam int ATTEN_W = 5;
    localparam int WB_AW = 4;
    localparam int WB_DW = 32;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_FLAGS = 4'h8;
    localparam int CTRL_REARM_BIT = 0;
    localparam int FLAG_START_ERR_BIT = 0;
    localparam int FLAG_WORD_BIT = 1;
    localparam int STAT_ATTEN_LSB = 0;
    localparam int STAT_SHIFT_LSB = 8;
    localparam int STAT_LIVE_BIT = 16;
    localparam int STAT_MODE_BIT = 17;
    localparam int STAT_LE_BIT = 18;
    localparam logic [5:0] SHIFT_RESET = 6'h00;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;
    localparam logic [31:0] WB_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_PRESET = 2'b01,
        ST_RUN = 2'b11
    } sa_state_type;

    typedef struct packed {
        logic atten_bit_8db;
        logic atten_bit_4db;
        logic atten_bit_2db;
        logic atten_bit_1db;
        logic atten_bit_half_db;
    } sa_atten_type;

    localparam sa_atten_type ATTEN_REF = 5'h00;
    localparam sa_atten_type ATTEN_8DB = 5'h10;

    typedef struct packed {
        logic serial_data;
        logic serial_clock;
        logic latch_load_enable;
        logic interface_select;
        logic powerup_preset_select;
        sa_atten_type atten_ctrl;
    } sa_pins_type;

    localparam int PINS_W = $bits(sa_pins_type);

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [WB_AW-1:0] adr;
        logic [WB_DW-1:0] dat;
    } sa_wb_req_type;
endpackage : sa_pkg

// ### logic/sa_sync.sv
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level; no word coherence is promised.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module sa_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule : sa_sync

// ### sim/sa_ctrl_model.sv
// Purpose: Behavioural controller that drives the serial and parallel pins of the attenuator.
// Assumes: Called from the bench; every pin changes just after a rising clk_sys edge.
// Notes: The serial clock rests low between words, so no stray shift can occur.
`timescale 1ns/1ps
module sa_ctrl_model
    import sa_pkg::*;
(
    input wire logic clk_sys,
    output sa_pkg::sa_pins_type pins
);
    initial pins = '0;

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle

    task automatic set_par(input logic sel, input logic pre, input logic le, input logic [4:0] c);
        @(posedge clk_sys);
        pins.interface_select <= sel;
        pins.powerup_preset_select <= pre;
        pins.latch_load_enable <= le;
        pins.atten_ctrl <= c;
    endtask : set_par

    // Eight cycles per bit give a 400 ns period, well below the highest allowed rate.
    task automatic send_word(input logic [5:0] w);
        for (int i = 5; i >= 0; i--) begin
            idle(1);
            pins.serial_data <= w[i];
            idle(3);
            pins.serial_clock <= 1'b1;
            idle(4);
            pins.serial_clock <= 1'b0;
        end
        idle(1);
        pins.serial_data <= ~w[0];
    endtask : send_word

    // The pulse starts well after the last falling edge, so the word is complete.
    task automatic pulse_le();
        idle(2);
        pins.latch_load_enable <= 1'b1;
        idle(6);
        pins.latch_load_enable <= 1'b0;
        idle(8);
    endtask : pulse_le
endmodule : sa_ctrl_model

// ### sim/step_attenuator_control_bench.sv
// Purpose: Self-checking bench of the step attenuator control block.
// Assumes: The controller model drives all pins; the bench speaks Wishbone.
// Notes: Resets stand in for power-up, so each power-up case is a fresh reset.
`timescale 1ns/1ps
module step_attenuator_control_bench;
    import sa_pkg::*;
    logic clk_sys;
    logic rst_n;
    sa_pins_type pins;
    sa_wb_req_type wb_req;
    logic [WB_DW-1:0] wb_dat_o;
    logic wb_ack_o;
    sa_atten_type atten;
    int failures;
    int compares;
    int exp_lat;
    int exp_sh;
    logic [31:0] rd;
    logic [5:0] w;
    logic [4:0] c;

    sa_top i_sa_top (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .atten(atten));
    sa_ctrl_model i_sa_ctrl_model (.clk_sys(clk_sys), .pins(pins));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t %s: saw %h, wanted %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_req <= '0;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask : wb

    task automatic do_reset(input logic sel, input logic pre, input logic le, input logic [4:0] v);
        i_sa_ctrl_model.set_par(sel, pre, le, v);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        exp_sh = 0;
        repeat (10) @(posedge clk_sys);
    endtask : do_reset

    task automatic send(input logic [5:0] v);
        i_sa_ctrl_model.send_word(v);
        for (int i = 5; i >= 0; i--) exp_sh = ((exp_sh << 1) | v[i]) & 63;
        i_sa_ctrl_model.idle(6);
    endtask : send

    initial begin
        rst_n = 1'b0;
        wb_req = '0;
        failures = 0;
        compares = 0;
        void'($urandom(32'hedfd));
        c = 5'($urandom);
        do_reset(1'b1, 1'b0, 1'b0, c);
        exp_lat = c;
        check(32'(atten), exp_lat, "serial power-up");
        for (int k = 0; k < 3; k++) begin
            w = {k == 2, 5'($urandom)};
            send(w);
            check(32'(atten), exp_lat, "held while shifting");
            wb(1'b0, ADDR_STATUS, WB_ZERO, rd);
            check(32'(rd[STAT_SHIFT_LSB +: SHIFT_W]), exp_sh, "shift order");
            check(32'(rd[STAT_ATTEN_LSB +: ATTEN_W]), exp_lat, "status attenuation");
            check(32'(rd[STAT_MODE_BIT]), 1, "status serial mode");
            check(32'(rd[STAT_LIVE_BIT]), 32'(k > 0), "status live");
            i_sa_ctrl_model.pulse_le();
            exp_lat = exp_sh & 31;
            check(32'(atten), exp_lat, "latched word");
        end
        wb(1'b0, ADDR_FLAGS, WB_ZERO, rd);
        check(32'(rd[FLAG_START_ERR_BIT]), 1, "start bit flag");
        check(32'(rd[FLAG_WORD_BIT]), 1, "word flag");
        wb(1'b1, ADDR_FLAGS, 32'h0000_0003, rd);
        wb(1'b0, ADDR_FLAGS, WB_ZERO, rd);
        check(rd, WB_ZERO, "flags cleared");
        i_sa_ctrl_model.set_par(1'b1, 1'b0, 1'b1, c);
        send(6'($urandom) & 6'h1F);
        i_sa_ctrl_model.idle(8);
        exp_lat = exp_sh & 31;
        check(32'(atten), exp_lat, "transparent latch");
        for (int p = 0; p < 2; p++) begin
            c = 5'($urandom);
            do_reset(1'b0, p[0], 1'b0, c);
            exp_lat = p[0] ? ATTEN_8DB : ATTEN_REF;
            check(32'(atten), exp_lat, "parallel preset");
            c = ~c;
            i_sa_ctrl_model.set_par(1'b0, p[0], 1'b0, c);
            i_sa_ctrl_model.idle(8);
            check(32'(atten), exp_lat, "preset held");
            i_sa_ctrl_model.pulse_le();
            exp_lat = c;
            check(32'(atten), exp_lat, "parallel latched");
        end
        c = 5'($urandom);
        do_reset(1'b0, 1'b1, 1'b1, c);
        exp_lat = c;
        check(32'(atten), exp_lat, "direct power-up");
        c = 5'($urandom);
        i_sa_ctrl_model.set_par(1'b0, 1'b1, 1'b1, c);
        i_sa_ctrl_model.idle(8);
        exp_lat = c;
        check(32'(atten), exp_lat, "direct follow");
        i_sa_ctrl_model.set_par(1'b0, 1'b1, 1'b0, ~c);
        wb(1'b1, ADDR_CTRL, 32'h0000_0001, rd);
        i_sa_ctrl_model.idle(8);
        exp_lat = ATTEN_8DB;
        check(32'(atten), exp_lat, "re-armed preset");
        wb(1'b0, 4'hC, WB_ZERO, rd);
        check(rd, WB_ZERO, "unmapped read");
        summarize();
    end
endmodule : step_attenuator_control_bench
